//--- logic/crsd_cfg.svh
`ifndef CRSD_CFG_SVH
`define CRSD_CFG_SVH

// Platform-to-system ratio strap codes.
`define CRSD_PR_16  4'h0
`define CRSD_PR_2   4'h2
`define CRSD_PR_3   4'h3
`define CRSD_PR_4   4'h4
`define CRSD_PR_5   4'h5
`define CRSD_PR_6   4'h6
`define CRSD_PR_8   4'h8
`define CRSD_PR_9   4'h9
`define CRSD_PR_10  4'hA
`define CRSD_PR_12  4'hC

// Platform multipliers as integers.
`define CRSD_MUL_16 5'h10
`define CRSD_MUL_2  5'h02
`define CRSD_MUL_3  5'h03
`define CRSD_MUL_4  5'h04
`define CRSD_MUL_5  5'h05
`define CRSD_MUL_6  5'h06
`define CRSD_MUL_8  5'h08
`define CRSD_MUL_9  5'h09
`define CRSD_MUL_10 5'h0A
`define CRSD_MUL_12 5'h0C
`define CRSD_MUL_0  5'h00

// Core ratio strap codes, high strap first; the fourth code is the 7:2 setting.
`define CRSD_CC_2_1 2'h0
`define CRSD_CC_5_2 2'h1
`define CRSD_CC_3_1 2'h2

// Core ratio in half steps: 2:1, 5:2, 3:1, 7:2.
`define CRSD_CR_00  4'h4
`define CRSD_CR_01  4'h5
`define CRSD_CR_10  4'h6
`define CRSD_CR_11  4'h7

// Memory bus clock divides the platform clock by this.
`define CRSD_MEM_DIV 2'h2

`endif

//--- logic/crsd_pkg.sv
package crsd_pkg;
    typedef struct packed {
        logic [3:0] platform_ratio_strap;
        logic       core_ratio_strap_hi;
        logic       core_ratio_strap_lo;
        logic       pci_width_strap_n;
    } crsd_straps_t;

    typedef struct packed {
        logic [4:0] platform_mul;
        logic       platform_reserved;
        logic [3:0] core_half_mul;
        logic [1:0] mem_div;
        logic       pci_64bit;
    } crsd_ratio_t;
endpackage

//--- logic/crsd_strap_decode.sv
`timescale 1ns/1ps
`include "crsd_cfg.svh"
module crsd_strap_decode (
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    input  wire crsd_pkg::crsd_straps_t strap_pins,
    output crsd_pkg::crsd_ratio_t       ratio_cfg,
    output logic                        cfg_pullup_en,
    output logic                        rst_drive_oe_n,
    output logic                        rst_drive
);
    import crsd_pkg::*;

    // ****************************************
    // Strap synchroniser
    // ****************************************
    // Pins are asynchronous, so three stages; a change counts once stages two and three agree.
    crsd_straps_t s1_q;
    crsd_straps_t s2_q;
    crsd_straps_t s3_q;
    crsd_straps_t stable_q;
    logic         rst_q;
    logic         locked_q;
    crsd_ratio_t  ratio_q;
    logic         pullup_q;
    logic         oe_n_q;

    wire          agree = (s2_q == s3_q);
    // A reset shorter than the synchroniser depth latches whatever the filter last held.
    wire          fire  = rst_q && !locked_q;

    always_ff @(posedge mclk) begin
        s1_q <= strap_pins;
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (agree) begin
            stable_q <= s3_q;
        end
    end

    // ****************************************
    // Decode
    // ****************************************
    // platform code table
    logic [4:0] pmul_d;
    always_comb begin
        case (stable_q.platform_ratio_strap)
            `CRSD_PR_16: pmul_d = `CRSD_MUL_16;
            `CRSD_PR_2:  pmul_d = `CRSD_MUL_2;
            `CRSD_PR_3:  pmul_d = `CRSD_MUL_3;
            `CRSD_PR_4:  pmul_d = `CRSD_MUL_4;
            `CRSD_PR_5:  pmul_d = `CRSD_MUL_5;
            `CRSD_PR_6:  pmul_d = `CRSD_MUL_6;
            `CRSD_PR_8:  pmul_d = `CRSD_MUL_8;
            `CRSD_PR_9:  pmul_d = `CRSD_MUL_9;
            `CRSD_PR_10: pmul_d = `CRSD_MUL_10;
            `CRSD_PR_12: pmul_d = `CRSD_MUL_12;
            default:     pmul_d = `CRSD_MUL_0;
        endcase
    end

    wire  [1:0] core_code = {stable_q.core_ratio_strap_hi, stable_q.core_ratio_strap_lo};
    logic [3:0] cmul_d;
    always_comb begin
        case (core_code)
            `CRSD_CC_2_1: cmul_d = `CRSD_CR_00;
            `CRSD_CC_5_2: cmul_d = `CRSD_CR_01;
            `CRSD_CC_3_1: cmul_d = `CRSD_CR_10;
            default:      cmul_d = `CRSD_CR_11;
        endcase
    end

    crsd_ratio_t ratio_d;
    always_comb begin
        ratio_d.platform_mul      = pmul_d;
        ratio_d.platform_reserved = (pmul_d == `CRSD_MUL_0);
        ratio_d.core_half_mul     = cmul_d;
        ratio_d.mem_div           = `CRSD_MEM_DIV;
        ratio_d.pci_64bit         = !stable_q.pci_width_strap_n;
    end

    // ****************************************
    // Reset-time latch and pin control
    // ****************************************
    // Straps are caught on the second clock after release, never under reset itself,
    // so the latch sees a settled synchroniser output.
    always_ff @(posedge mclk) begin
        rst_q <= rstn;
        if (!rstn) begin
            locked_q <= 1'b0;
            ratio_q  <= '0;
            pullup_q <= 1'b1;
            oe_n_q   <= 1'b0;
        end else begin
            if (fire) begin
                locked_q <= 1'b1;
                ratio_q  <= ratio_d;
            end
            pullup_q <= 1'b0;
            oe_n_q   <= 1'b0;
        end
    end

    assign ratio_cfg      = ratio_q;
    assign cfg_pullup_en  = pullup_q;
    // driven during reset
    // The enable never releases, so the pin has a defined level from the first edge on.
    assign rst_drive_oe_n = oe_n_q;
    assign rst_drive      = rst_q;

    // ****************************************
    // Checks
    // ****************************************
    property p_hold;
        @(posedge mclk) disable iff (!rstn) locked_q |=> $stable(ratio_q);
    endproperty
    a_hold: assert property (p_hold) else $error("Ratio changed after latch.");

    // a_pull and a_drive run through reset on purpose, since that is when they matter.
    property p_pull;
        @(posedge mclk) !rstn |=> pullup_q;
    endproperty
    a_pull: assert property (p_pull) else $error("Pull-up off in reset.");

    property p_pulloff;
        @(posedge mclk) disable iff (!rstn) $past(rstn) |-> !pullup_q;
    endproperty
    a_pulloff: assert property (p_pulloff) else $error("Pull-up left on.");

    property p_drive;
        @(posedge mclk) !rstn |=> !rst_drive_oe_n && !rst_drive;
    endproperty
    a_drive: assert property (p_drive) else $error("Output not driven low in reset.");

    property p_lock;
        @(posedge mclk) disable iff (!rstn) fire |=> locked_q && ratio_q == $past(ratio_d);
    endproperty
    a_lock: assert property (p_lock) else $error("Latch missed.");

    property p_mem;
        @(posedge mclk) disable iff (!rstn) locked_q |-> ratio_q.mem_div == `CRSD_MEM_DIV;
    endproperty
    a_mem: assert property (p_mem) else $error("Memory divide wrong.");

    property p_res;
        @(posedge mclk) disable iff (!rstn)
            locked_q |-> ratio_q.platform_reserved == (ratio_q.platform_mul == `CRSD_MUL_0);
    endproperty
    a_res: assert property (p_res) else $error("Reserved flag wrong.");

    property p_core;
        @(posedge mclk) disable iff (!rstn)
            locked_q |-> ratio_q.core_half_mul inside {[`CRSD_CR_00:`CRSD_CR_11]};
    endproperty
    a_core: assert property (p_core) else $error("Core ratio out of range.");

    property p_zero;
        @(posedge mclk) !rstn |=> ratio_q == '0;
    endproperty
    a_zero: assert property (p_zero) else $error("Ratio not cleared in reset.");

    property p_rstval;
        @(posedge mclk) disable iff (!rstn) $past(rstn) |-> rst_drive;
    endproperty
    a_rstval: assert property (p_rstval) else $error("Output not released after reset.");

    property p_sync;
        @(posedge mclk) agree |=> stable_q == $past(s3_q);
    endproperty
    a_sync: assert property (p_sync) else $error("Strap filter missed.");

    property p_filter;
        @(posedge mclk) !agree |=> $stable(stable_q);
    endproperty
    a_filter: assert property (p_filter) else $error("Unfiltered strap change.");

    property p_width;
        @(posedge mclk) disable iff (!rstn)
            fire |=> ratio_q.pci_64bit == !$past(stable_q.pci_width_strap_n);
    endproperty
    a_width: assert property (p_width) else $error("Width select wrong.");

    property p_plat16;
        @(posedge mclk) disable iff (!rstn)
            fire && stable_q.platform_ratio_strap == `CRSD_PR_16 |=>
                ratio_q.platform_mul == `CRSD_MUL_16;
    endproperty
    a_plat16: assert property (p_plat16) else $error("Code zero not decoded as 16.");

    // ****************************************
    // Release sequence checks
    // ****************************************
    // Release takes two edges: pull-ups drop on the first, the ratio latches on the second.
    // A reset pulse inside those two edges would restart the order, so none is checked.
    sequence s_release;
        !rstn ##1 rstn;
    endsequence

    sequence s_pull_drop;
        !pullup_q && !locked_q;
    endsequence

    sequence s_latched;
        locked_q && !pullup_q;
    endsequence

    property p_release;
        @(posedge mclk) s_release |=> s_pull_drop ##1 s_latched;
    endproperty
    a_release: assert property (p_release) else $error("Release steps out of order.");
endmodule

//--- verification/clock_ratio_strap_decode_tb.sv
`timescale 1ns/1ps
module clock_ratio_strap_decode_tb;
    import crsd_pkg::*;
    logic         mclk = 1'b0;
    logic         rstn = 1'b0;
    logic         w64 = 1'b0;
    logic [3:0]   pc = 4'h0;
    logic [1:0]   cc = 2'h0;
    crsd_straps_t st;
    crsd_ratio_t  ro;
    logic         pu;
    logic         oen;
    logic         rso;
    int           fail_count = 0;
    int           n_compared = 0;

    initial forever #10 mclk = ~mclk;

    crsd_board_model brd (.plat_code(pc), .core_code(cc), .want_64(w64), .straps(st));
    crsd_strap_decode uut (
        .mclk           (mclk),
        .rstn           (rstn),
        .strap_pins     (st),
        .ratio_cfg      (ro),
        .cfg_pullup_en  (pu),
        .rst_drive_oe_n (oen),
        .rst_drive      (rso)
    );

    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Reserved codes give a zero multiplier; code 0 gives 16; the others equal their code.
    function automatic logic [4:0] mul_of(input logic [3:0] c);
        case (c)
            4'h0: return 5'h10;
            4'h1, 4'h7, 4'hB, 4'hD, 4'hE, 4'hF: return 5'h00;
            default: return {1'b0, c};
        endcase
    endfunction

    // Core multiplier counts half steps from 2:1; memory divide is always two.
    function automatic logic [12:0] exp_ratio(input logic [3:0] p, input logic [1:0] c,
                                              input logic w);
        return {mul_of(p), mul_of(p) == 5'h00, 4'h4 + {2'h0, c}, 2'h2, w};
    endfunction

    // Start-up reset is three edges long, with the straps at their initial levels.
    task automatic startup_case();
        repeat (3) @(negedge mclk);
        check({10'h000, pu, oen, rso}, 13'h0004);
        check(ro, 13'h0000);
        rstn = 1'b1;
        @(negedge mclk);
        check({10'h000, pu, oen, rso}, 13'h0001);
        check(ro, 13'h0000);
        @(negedge mclk);
        check(ro, exp_ratio(pc, cc, w64));
    endtask

    // Four cycles low lets the three-stage strap synchroniser settle.
    task automatic pulse_reset();
        @(negedge mclk);
        rstn = 1'b0;
        repeat (4) @(negedge mclk);
        check({10'h0, pu, oen, rso}, 13'h004);
        check(ro, 13'h0);
        rstn = 1'b1;
        @(negedge mclk);
        check({10'h0, pu, oen, rso}, 13'h001);
        check(ro, 13'h0);
    endtask

    task automatic latch_case(input logic [3:0] p, input logic [1:0] c, input logic w);
        pc = p;
        cc = c;
        w64 = w;
        pulse_reset();
        @(negedge mclk);
        check(ro, exp_ratio(p, c, w));
    endtask

    // A one-cycle glitch two edges before release must be filtered out.
    task automatic glitch_case();
        pc = 4'h3;
        cc = 2'h1;
        w64 = 1'b0;
        @(negedge mclk);
        rstn = 1'b0;
        repeat (4) @(negedge mclk);
        pc = 4'h9;
        cc = 2'h2;
        w64 = 1'b1;
        @(negedge mclk);
        pc = 4'h3;
        cc = 2'h1;
        w64 = 1'b0;
        @(negedge mclk);
        rstn = 1'b1;
        repeat (2) @(negedge mclk);
        check(ro, exp_ratio(4'h3, 2'h1, 1'b0));
    endtask

    // legal board setting: 5:1 on a 42 MHz input, near 208 MHz platform.
    task automatic hold_case();
        latch_case(4'h5, 2'h3, 1'b1);
        pc = 4'hC;
        cc = 2'h0;
        w64 = 1'b0;
        repeat (6) @(negedge mclk);
        check(ro, exp_ratio(4'h5, 2'h3, 1'b1));
        check({10'h0, pu, oen, rso}, 13'h001);
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        startup_case();
        for (int i = 0; i < 16; i++) begin
            latch_case(i[3:0], i[1:0], i[0]);
        end
        glitch_case();
        hold_case();
        test_done();
    end
endmodule

//--- verification/crsd_board_model.sv
`timescale 1ns/1ps
module crsd_board_model (
    input  wire logic [3:0]        plat_code,
    input  wire logic [1:0]        core_code,
    input  wire logic              want_64,
    output crsd_pkg::crsd_straps_t straps
);
    import crsd_pkg::*;
    assign straps = '{plat_code, core_code[1], core_code[0], ~want_64};
endmodule
